// ---- sim/gblc_cache_model.sv ----
// behavioural data cache answering byte reads one cycle after a request
`timescale 1ns/100ps
`default_nettype none
module gblc_cache_model (
  input  wire logic        sys_clk,
  input  wire logic        clk_en,
  input  wire logic        mem_req,
  input  wire logic [31:0] mem_addr,
  output var  logic [7:0]  mem_rdata
);
  initial mem_rdata = 8'h5a;
  always @(posedge sys_clk) begin
    if (clk_en) begin
      if (mem_req) begin
        // byte contents follow the address; held while the core is frozen
        mem_rdata <= mem_addr[7:0] ^ mem_addr[15:8] ^ 8'hc3;
      end else begin
        // no request: toggle so a stale byte never looks like an answer
        mem_rdata <= ~mem_rdata;
      end
    end
  end
endmodule : gblc_cache_model
`default_nettype wire

// ---- sim/gblc_slice_tb_top.sv ----
// self-checking bench for the guarded byte load and unsigned compare slice
`timescale 1ns/100ps
`default_nettype none
module gblc_slice_tb_top;
  typedef struct {
    gblc_pkg::gblc_op_t op;
    logic [31:0]        s1;
    logic [31:0]        s2;
    logic [6:0]         md;
    logic               gp;
    logic               gv;
    logic [31:0]        ex;
  } gblc_row_t;
  typedef struct {
    int          due;
    logic [6:0]  dest;
    logic [31:0] val;
  } gblc_exp_t;
  localparam gblc_pkg::gblc_op_t LD = gblc_pkg::OP_LD_DISP;
  localparam gblc_pkg::gblc_op_t LX = gblc_pkg::OP_LD_IDX;
  localparam gblc_pkg::gblc_op_t LE = gblc_pkg::OP_CMP_LEQ;
  localparam gblc_pkg::gblc_op_t LI = gblc_pkg::OP_CMP_LEQI;
  localparam gblc_pkg::gblc_op_t LS = gblc_pkg::OP_CMP_LES;
  localparam int NROWS = 27;
  // ex is the load address or the compare result; plain memory only
  gblc_row_t rows [NROWS] = '{
    '{LD, 32'hd00, 32'h100, 7'h02, 1'b0, 1'b0, 32'hd02},
    '{LD, 32'hd04, 32'h100, 7'h7c, 1'b1, 1'b0, 32'h0},
    '{LD, 32'hd04, 32'h100, 7'h7c, 1'b1, 1'b1, 32'hd00},
    '{LD, 32'hd05, 32'h0, 7'h7c, 1'b0, 1'b0, 32'hd01},
    '{LD, 32'h0, 32'h0, 7'h40, 1'b0, 1'b0, 32'hffffffc0},
    '{LD, 32'h10, 32'h0, 7'h3f, 1'b1, 1'b1, 32'h4f},
    '{LX, 32'hd00, 32'h2, 7'h05, 1'b0, 1'b0, 32'hd02},
    '{LX, 32'hd04, 32'hfffffffc, 7'h0, 1'b1, 1'b0, 32'h0},
    '{LX, 32'hd04, 32'hfffffffc, 7'h0, 1'b1, 1'b1, 32'hd00},
    '{LX, 32'hd05, 32'hfffffffc, 7'h0, 1'b0, 1'b0, 32'hd01},
    '{LE, 32'h3, 32'h4, 7'h0, 1'b0, 1'b0, 32'h1},
    '{LE, 32'h1000, 32'h100, 7'h0, 1'b1, 1'b1, 32'h0},
    '{LE, 32'h80000000, 32'h4, 7'h0, 1'b0, 1'b0, 32'h0},
    '{LE, 32'h8000000, 32'h8000000, 7'h0, 1'b0, 1'b0, 32'h1},
    '{LE, 32'h100, 32'h3, 7'h0, 1'b1, 1'b0, 32'h0},
    '{LI, 32'h3, 32'hffffffff, 7'h02, 1'b0, 1'b0, 32'h0},
    '{LI, 32'h3, 32'hffffffff, 7'h03, 1'b0, 1'b0, 32'h1},
    '{LI, 32'h3, 32'h0, 7'h04, 1'b0, 1'b0, 32'h1},
    '{LI, 32'h100, 32'h0, 7'h3f, 1'b1, 1'b1, 32'h0},
    '{LI, 32'h80, 32'hffffffff, 7'h7f, 1'b0, 1'b0, 32'h0},
    '{LI, 32'h7f, 32'h0, 7'h7f, 1'b0, 1'b0, 32'h1},
    '{LS, 32'h3, 32'h4, 7'h0, 1'b0, 1'b0, 32'h1},
    '{LS, 32'h1000, 32'h100, 7'h0, 1'b1, 1'b1, 32'h0},
    '{LS, 32'h8000000, 32'h8000000, 7'h0, 1'b0, 1'b0, 32'h0},
    '{LS, 32'h100, 32'h3, 7'h0, 1'b1, 1'b0, 32'h0},
    '{LS, 32'h4, 32'h80000000, 7'h0, 1'b0, 1'b0, 32'h1},
    '{gblc_pkg::OP_NONE, 32'hd00, 32'h0, 7'h0, 1'b0, 1'b0, 32'h0}
  };
  logic               sys_clk, srst, clk_en, issue_valid, guard_present;
  logic               mem_req, ld_wb_valid, cmp_wb_valid, mon_on, rst_last;
  gblc_pkg::gblc_op_t issue_op;
  logic [31:0]        first_source_register, second_source_register, guard_value;
  logic [31:0]        mem_addr, ld_wb_data, cmp_wb_data, cur_exp;
  logic [6:0]         issue_modifier, issue_dest, ld_wb_dest, cmp_wb_dest;
  logic [7:0]         mem_rdata;
  int                 ncyc, fail_count, num_checks;
  gblc_exp_t          ld_q[$], cmp_q[$], rq_q[$];

  gblc_slice i_gblc_slice (.sys_clk(sys_clk), .srst(srst), .clk_en(clk_en),
    .issue_valid(issue_valid), .issue_op(issue_op),
    .first_source_register(first_source_register),
    .second_source_register(second_source_register), .issue_modifier(issue_modifier),
    .guard_present(guard_present), .guard_value(guard_value), .issue_dest(issue_dest),
    .mem_req(mem_req), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
    .ld_wb_valid(ld_wb_valid), .ld_wb_dest(ld_wb_dest), .ld_wb_data(ld_wb_data),
    .cmp_wb_valid(cmp_wb_valid), .cmp_wb_dest(cmp_wb_dest), .cmp_wb_data(cmp_wb_data));
  gblc_cache_model i_gblc_cache_model (.sys_clk(sys_clk), .clk_en(clk_en),
    .mem_req(mem_req), .mem_addr(mem_addr), .mem_rdata(mem_rdata));

  function automatic logic [7:0] mem_byte(input logic [31:0] a);
    return a[7:0] ^ a[15:8] ^ 8'hc3;
  endfunction : mem_byte

  task automatic mismatch(input string m);
    fail_count++;
    $display("CHECK FAILED at %0t: %s", $time, m);
  endtask : mismatch

  task automatic summarize;
    $display("checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : summarize

  // head of q is due while ncyc matches; strobe must agree exactly
  task automatic check_port(input string nm, input logic v, input logic [6:0] d,
                            input logic [31:0] x, input gblc_exp_t q[$]);
    logic due;
    due = (q.size() > 0) && (q[0].due == ncyc);
    num_checks++;
    if (v !== due) mismatch({nm, " strobe wrong"});
    else if (due && (d !== q[0].dest || x !== q[0].val)) mismatch({nm, " value wrong"});
  endtask : check_port

  task automatic issue(input gblc_row_t r, input logic [6:0] d);
    issue_valid            <= 1'b1;
    issue_op               <= r.op;
    first_source_register  <= r.s1;
    second_source_register <= r.s2;
    issue_modifier         <= r.md;
    guard_present          <= r.gp;
    // upper guard bits set so that only bit 0 can decide
    guard_value            <= {31'h7fffffff, r.gv};
    issue_dest             <= d;
    cur_exp                <= r.ex;
    @(posedge sys_clk);
  endtask : issue

  task automatic idle(input int n);
    issue_valid <= 1'b0;
    repeat (n) @(posedge sys_clk);
  endtask : idle

  always @(posedge sys_clk) begin
    rst_last = srst;
    if (srst) begin
      mon_on = 1'b1;
      ld_q.delete();
      cmp_q.delete();
      rq_q.delete();
    end else if (clk_en) begin
      if (ld_q.size() > 0 && ld_q[0].due == ncyc) void'(ld_q.pop_front());
      if (cmp_q.size() > 0 && cmp_q[0].due == ncyc) void'(cmp_q.pop_front());
      if (rq_q.size() > 0 && rq_q[0].due == ncyc) void'(rq_q.pop_front());
      if (issue_valid && (!guard_present || guard_value[0])) begin
        if (issue_op == LD || issue_op == LX) begin
          rq_q.push_back('{ncyc + 1, 7'h0, cur_exp});
          ld_q.push_back('{ncyc + 3, issue_dest, {24'h0, mem_byte(cur_exp)}});
        end else if (issue_op == LE || issue_op == LI || issue_op == LS) begin
          cmp_q.push_back('{ncyc + 1, issue_dest, cur_exp});
        end
      end
      ncyc++;
    end
  end

  always @(negedge sys_clk) begin
    if (mon_on) begin
      check_port("cache", mem_req, 7'h0, mem_addr, rq_q);
      check_port("load", ld_wb_valid, ld_wb_dest, ld_wb_data,
                 ld_q);
      check_port("cmp", cmp_wb_valid, cmp_wb_dest, cmp_wb_data,
                 cmp_q);
      if (rst_last) begin
        num_checks++;
        if (mem_addr !== 32'h0 || ld_wb_data !== 32'h0 || cmp_wb_data !== 32'h0 ||
            ld_wb_dest !== 7'h0 || cmp_wb_dest !== 7'h0)
          mismatch("outputs not cleared by reset");
      end
    end
  end

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  initial begin
    #(400 * 8);
    mismatch("watchdog expired");
    summarize();
  end

  initial begin
    {srst, clk_en, mon_on, rst_last} = 4'b1100;
    {issue_valid, guard_present} = 2'b00;
    issue_op = gblc_pkg::OP_NONE;
    {first_source_register, second_source_register, guard_value, cur_exp} = '0;
    {issue_modifier, issue_dest} = '0;
    ncyc = 0;
    fail_count = 0;
    num_checks = 0;
    repeat (3) @(posedge sys_clk);
    srst <= 1'b0;
    // all rows back to back, loads and compares mixed
    for (int i = 0; i < NROWS; i++) issue(rows[i], 7'(i + 1));
    idle(6);
    // freeze with a compare strobe standing and a load in flight
    issue(rows[3], 7'h40);
    issue(rows[10], 7'h41);
    clk_en <= 1'b0;
    issue(rows[21], 7'h42);
    repeat (3) @(posedge sys_clk);
    clk_en <= 1'b1;
    idle(6);
    // reset with work in flight, then issue right after release
    issue(rows[0], 7'h50);
    issue(rows[13], 7'h51);
    srst <= 1'b1;
    issue(rows[6], 7'h52);
    srst <= 1'b0;
    issue(rows[8], 7'h53);
    idle(8);
    summarize();
  end
endmodule : gblc_slice_tb_top
`default_nettype wire

// ---- src/gblc_cmp_unit.sv ----
// single-cycle unsigned greater-or-equal / greater-than unit with guarded write-back
`timescale 1ns/100ps
`default_nettype none
module gblc_cmp_unit (
  input  wire logic                        sys_clk,
  input  wire logic                        srst,
  input  wire logic                        clk_en,
  input  wire logic                        go,
  input  wire gblc_pkg::gblc_cmp_t         kind,
  input  wire logic [gblc_pkg::DATA_W-1:0] lhs,
  input  wire logic [gblc_pkg::DATA_W-1:0] rhs,
  input  wire logic [gblc_pkg::DEST_W-1:0] dest,
  output logic                             wb_valid,
  output logic [gblc_pkg::DEST_W-1:0]      wb_dest,
  output logic [gblc_pkg::DATA_W-1:0]      wb_data
);

  gblc_pkg::gblc_cmp_state_t st_q;
  gblc_pkg::gblc_cmp_state_t st_d;
  logic                      hit;

  always_comb begin
    st_d = st_q;
    // plain unsigned relations on full 32-bit words
    case (kind)
      gblc_pkg::CMP_GEQ: hit = (lhs >= rhs);
      gblc_pkg::CMP_GTR: hit = (lhs > rhs);
      default:           hit = 1'b0;
    endcase
    if (clk_en) begin
      st_d.vld = go;
      if (go) begin
        st_d.dest = dest;
        st_d.data = hit ? gblc_pkg::CMP_TRUE : gblc_pkg::CMP_FALSE;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_q <= gblc_pkg::CMP_STATE_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign wb_valid = st_q.vld;
  assign wb_dest  = st_q.dest;
  assign wb_data  = st_q.data;

endmodule : gblc_cmp_unit
`default_nettype wire

// ---- src/gblc_pkg.sv ----
// constants, types and helpers shared by the guarded byte load and compare slice
package gblc_pkg;

  localparam int unsigned DATA_W    = 32;
  localparam int unsigned BYTE_W    = 8;
  localparam int unsigned MOD_W     = 7;
  localparam int unsigned DEST_W    = 7;
  localparam int unsigned GUARD_BIT = 0;
  localparam int unsigned SIGN_BIT  = MOD_W - 1;
  localparam int unsigned LD_LAT    = 3;
  localparam int unsigned CMP_LAT   = 1;

  localparam logic [DATA_W-1:0] CMP_TRUE  = 32'h1;
  localparam logic [DATA_W-1:0] CMP_FALSE = 32'h0;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_LD_DISP,
    OP_LD_IDX,
    OP_CMP_LEQ,
    OP_CMP_LEQI,
    OP_CMP_LES
  } gblc_op_t;

  typedef enum logic {
    CMP_GEQ,
    CMP_GTR
  } gblc_cmp_t;

  typedef struct packed {
    logic              s1_vld;
    logic [DATA_W-1:0] s1_addr;
    logic [DEST_W-1:0] s1_dest;
    logic              s2_vld;
    logic [DEST_W-1:0] s2_dest;
    logic              s3_vld;
    logic [DEST_W-1:0] s3_dest;
    logic [DATA_W-1:0] s3_data;
  } gblc_ld_state_t;

  typedef struct packed {
    logic              vld;
    logic [DEST_W-1:0] dest;
    logic [DATA_W-1:0] data;
  } gblc_cmp_state_t;

  localparam gblc_ld_state_t  LD_STATE_RST  = '0;
  localparam gblc_cmp_state_t CMP_STATE_RST = '0;

  function automatic logic [DATA_W-1:0] sext_mod(input logic [MOD_W-1:0] m);
    sext_mod = {{(DATA_W-MOD_W){m[SIGN_BIT]}}, m};
  endfunction : sext_mod

  function automatic logic [DATA_W-1:0] zext_mod(input logic [MOD_W-1:0] m);
    zext_mod = {{(DATA_W-MOD_W){1'b0}}, m};
  endfunction : zext_mod

  function automatic logic [DATA_W-1:0] zext_byte(input logic [BYTE_W-1:0] b);
    zext_byte = {{(DATA_W-BYTE_W){1'b0}}, b};
  endfunction : zext_byte

  function automatic logic guard_true(input logic present, input logic [DATA_W-1:0] g);
    guard_true = !present || g[GUARD_BIT];
  endfunction : guard_true

  function automatic logic is_load(input gblc_op_t op);
    is_load = (op == OP_LD_DISP) || (op == OP_LD_IDX);
  endfunction : is_load

  function automatic logic is_cmp(input gblc_op_t op);
    is_cmp = (op == OP_CMP_LEQ) || (op == OP_CMP_LEQI) || (op == OP_CMP_LES);
  endfunction : is_cmp

endpackage : gblc_pkg

// ---- src/gblc_slice.sv ----
// guarded unsigned byte loads and unsigned compares, one issue port, two write-back ports
`timescale 1ns/100ps
`default_nettype none
module gblc_slice (
  input  wire logic                        sys_clk,
  input  wire logic                        srst,
  input  wire logic                        clk_en,
  input  wire logic                        issue_valid,
  input  wire gblc_pkg::gblc_op_t          issue_op,
  input  wire logic [gblc_pkg::DATA_W-1:0] first_source_register,
  input  wire logic [gblc_pkg::DATA_W-1:0] second_source_register,
  input  wire logic [gblc_pkg::MOD_W-1:0]  issue_modifier,
  input  wire logic                        guard_present,
  input  wire logic [gblc_pkg::DATA_W-1:0] guard_value,
  input  wire logic [gblc_pkg::DEST_W-1:0] issue_dest,
  output logic                             mem_req,
  output logic [gblc_pkg::DATA_W-1:0]      mem_addr,
  input  wire logic [gblc_pkg::BYTE_W-1:0] mem_rdata,
  output logic                             ld_wb_valid,
  output logic [gblc_pkg::DEST_W-1:0]      ld_wb_dest,
  output logic [gblc_pkg::DATA_W-1:0]      ld_wb_data,
  output logic                             cmp_wb_valid,
  output logic [gblc_pkg::DEST_W-1:0]      cmp_wb_dest,
  output logic [gblc_pkg::DATA_W-1:0]      cmp_wb_data
);

  gblc_pkg::gblc_ld_state_t ld_q;
  gblc_pkg::gblc_ld_state_t ld_d;
  logic                     guard_ok;
  logic                     ld_go;
  logic                     cmp_go;
  logic [gblc_pkg::DATA_W-1:0] ld_addr;
  gblc_pkg::gblc_cmp_t      cmp_kind;
  logic [gblc_pkg::DATA_W-1:0] cmp_lhs;
  logic [gblc_pkg::DATA_W-1:0] cmp_rhs;

  // absent guard counts as true
  assign guard_ok = gblc_pkg::guard_true(guard_present, guard_value);
  // a false guard never reaches the cache, so no status bits move either
  assign ld_go  = issue_valid && gblc_pkg::is_load(issue_op) && guard_ok;
  assign cmp_go = issue_valid && gblc_pkg::is_cmp(issue_op) && guard_ok;

  // address adder wraps modulo 2^32, negative index just wraps around
  always_comb begin
    case (issue_op)
      gblc_pkg::OP_LD_DISP:
        ld_addr = first_source_register + gblc_pkg::sext_mod(issue_modifier);
      gblc_pkg::OP_LD_IDX:
        ld_addr = first_source_register + second_source_register;
      default:
        ld_addr = first_source_register;
    endcase
  end

  // no separate less-than paths: operands swap into the greater-or-equal / greater-than unit
  always_comb begin
    case (issue_op)
      gblc_pkg::OP_CMP_LEQ: begin
        cmp_kind = gblc_pkg::CMP_GEQ;
        cmp_lhs  = second_source_register;
        cmp_rhs  = first_source_register;
      end
      gblc_pkg::OP_CMP_LEQI: begin
        cmp_kind = gblc_pkg::CMP_GEQ;
        cmp_lhs  = gblc_pkg::zext_mod(issue_modifier);
        cmp_rhs  = first_source_register;
      end
      gblc_pkg::OP_CMP_LES: begin
        cmp_kind = gblc_pkg::CMP_GTR;
        cmp_lhs  = second_source_register;
        cmp_rhs  = first_source_register;
      end
      default: begin
        cmp_kind = gblc_pkg::CMP_GEQ;
        cmp_lhs  = second_source_register;
        cmp_rhs  = first_source_register;
      end
    endcase
  end

  // load pipe: request stage, cache wait stage, result stage
  always_comb begin
    ld_d = ld_q;
    if (clk_en) begin
      ld_d.s1_vld = ld_go;
      if (ld_go) begin
        ld_d.s1_addr = ld_addr;
        ld_d.s1_dest = issue_dest;
      end
      ld_d.s2_vld  = ld_q.s1_vld;
      ld_d.s2_dest = ld_q.s1_dest;
      ld_d.s3_vld  = ld_q.s2_vld;
      if (ld_q.s2_vld) begin
        ld_d.s3_dest = ld_q.s2_dest;
        // byte taken as is; byte order only matters for wider loads
        ld_d.s3_data = gblc_pkg::zext_byte(mem_rdata);
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ld_q <= gblc_pkg::LD_STATE_RST;
    end else begin
      ld_q <= ld_d;
    end
  end

  assign mem_req     = ld_q.s1_vld;
  assign mem_addr    = ld_q.s1_addr;
  assign ld_wb_valid = ld_q.s3_vld;
  assign ld_wb_dest  = ld_q.s3_dest;
  assign ld_wb_data  = ld_q.s3_data;

  gblc_cmp_unit u_cmp (
    .sys_clk  (sys_clk),
    .srst     (srst),
    .clk_en   (clk_en),
    .go       (cmp_go),
    .kind     (cmp_kind),
    .lhs      (cmp_lhs),
    .rhs      (cmp_rhs),
    .dest     (issue_dest),
    .wb_valid (cmp_wb_valid),
    .wb_dest  (cmp_wb_dest),
    .wb_data  (cmp_wb_data)
  );

  // checking helpers, written independently of the datapath functions
  logic [gblc_pkg::DATA_W-1:0] chk_disp_addr;
  logic [gblc_pkg::DATA_W-1:0] chk_idx_addr;
  logic                        chk_guard;
  logic [gblc_pkg::LD_LAT-1:0]  chk_ld_sr;
  logic [gblc_pkg::CMP_LAT-1:0] chk_cmp_sr;

  assign chk_disp_addr = first_source_register
                       + {{25{issue_modifier[6]}}, issue_modifier};
  assign chk_idx_addr  = first_source_register + second_source_register;
  assign chk_guard     = (guard_present == 1'b0) || (guard_value[0] == 1'b1);

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      chk_ld_sr  <= '0;
      chk_cmp_sr <= '0;
    end else if (clk_en) begin
      chk_ld_sr  <= {chk_ld_sr[gblc_pkg::LD_LAT-2:0],
                     issue_valid && chk_guard &&
                     ((issue_op == gblc_pkg::OP_LD_DISP) ||
                      (issue_op == gblc_pkg::OP_LD_IDX))};
      chk_cmp_sr <= issue_valid && chk_guard &&
                    ((issue_op == gblc_pkg::OP_CMP_LEQ) ||
                     (issue_op == gblc_pkg::OP_CMP_LEQI) ||
                     (issue_op == gblc_pkg::OP_CMP_LES));
    end
  end

  sequence s_go(gblc_pkg::gblc_op_t op);
    clk_en && issue_valid && (issue_op == op) && chk_guard;
  endsequence

  sequence s_blocked_load;
    clk_en && issue_valid && !chk_guard &&
    ((issue_op == gblc_pkg::OP_LD_DISP) || (issue_op == gblc_pkg::OP_LD_IDX));
  endsequence

  sequence s_blocked_cmp;
    clk_en && issue_valid && !chk_guard &&
    ((issue_op == gblc_pkg::OP_CMP_LEQ) || (issue_op == gblc_pkg::OP_CMP_LEQI) ||
     (issue_op == gblc_pkg::OP_CMP_LES));
  endsequence

  sequence s_two_more_edges;
    ##1 clk_en ##1 clk_en;
  endsequence

  property p_ld_disp_addr;
    @(posedge sys_clk) disable iff (srst)
      s_go(gblc_pkg::OP_LD_DISP) |=> mem_req && (mem_addr == $past(chk_disp_addr));
  endproperty
  a_ld_disp_addr: assert property (p_ld_disp_addr)
    else $error("displacement load address wrong");

  property p_ld_idx_addr;
    @(posedge sys_clk) disable iff (srst)
      s_go(gblc_pkg::OP_LD_IDX) |=> mem_req && (mem_addr == $past(chk_idx_addr));
  endproperty
  a_ld_idx_addr: assert property (p_ld_idx_addr)
    else $error("indexed load address wrong");

  property p_ld_result;
    @(posedge sys_clk) disable iff (srst)
      (ld_q.s2_vld && clk_en) |=>
        ld_wb_valid && (ld_wb_data == {24'h0, $past(mem_rdata)});
  endproperty
  a_ld_result: assert property (p_ld_result)
    else $error("load result not the zero-extended cache byte");

  property p_ld_dest;
    @(posedge sys_clk) disable iff (srst)
      (s_go(gblc_pkg::OP_LD_DISP) or s_go(gblc_pkg::OP_LD_IDX)) ##0 s_two_more_edges
        |=> ld_wb_valid && (ld_wb_dest == $past(issue_dest, 3));
  endproperty
  a_ld_dest: assert property (p_ld_dest)
    else $error("load write-back missing or to wrong destination");

  property p_ld_guard_false;
    @(posedge sys_clk) disable iff (srst)
      s_blocked_load |=> (!mem_req and (clk_en [*2] |=> !ld_wb_valid));
  endproperty
  a_ld_guard_false: assert property (p_ld_guard_false)
    else $error("false-guard load had a side effect");

  property p_ld_latency;
    @(posedge sys_clk) disable iff (srst)
      ld_wb_valid == chk_ld_sr[gblc_pkg::LD_LAT-1];
  endproperty
  a_ld_latency: assert property (p_ld_latency)
    else $error("load write-back not three cycles after issue");

  property p_cmp_leq;
    @(posedge sys_clk) disable iff (srst)
      s_go(gblc_pkg::OP_CMP_LEQ) |=> cmp_wb_valid &&
        (cmp_wb_data == (($past(first_source_register) <= $past(second_source_register))
                         ? 32'h1 : 32'h0));
  endproperty
  a_cmp_leq: assert property (p_cmp_leq)
    else $error("less-or-equal result wrong");

  property p_cmp_leqi;
    @(posedge sys_clk) disable iff (srst)
      s_go(gblc_pkg::OP_CMP_LEQI) |=> cmp_wb_valid &&
        (cmp_wb_data == (($past(first_source_register) <= {25'h0, $past(issue_modifier)})
                         ? 32'h1 : 32'h0));
  endproperty
  a_cmp_leqi: assert property (p_cmp_leqi)
    else $error("immediate less-or-equal result wrong");

  property p_cmp_les;
    @(posedge sys_clk) disable iff (srst)
      s_go(gblc_pkg::OP_CMP_LES) |=> cmp_wb_valid &&
        (cmp_wb_data == (($past(first_source_register) < $past(second_source_register))
                         ? 32'h1 : 32'h0)) && (cmp_wb_dest == $past(issue_dest));
  endproperty
  a_cmp_les: assert property (p_cmp_les)
    else $error("less-than result wrong");

  // a false guard must leave the old destination and value in place
  property p_cmp_guard;
    @(posedge sys_clk) disable iff (srst)
      s_blocked_cmp |=> !cmp_wb_valid && $stable(cmp_wb_dest) && $stable(cmp_wb_data);
  endproperty
  a_cmp_guard: assert property (p_cmp_guard)
    else $error("compare write-back without a true guard");

  property p_cmp_latency;
    @(posedge sys_clk) disable iff (srst)
      cmp_wb_valid == chk_cmp_sr[0];
  endproperty
  a_cmp_latency: assert property (p_cmp_latency)
    else $error("compare write-back not one cycle after a guarded issue");

  property p_freeze;
    @(posedge sys_clk) disable iff (srst)
      !clk_en |=> $stable(mem_req) && $stable(mem_addr) && $stable(ld_wb_valid)
        && $stable(ld_wb_data) && $stable(cmp_wb_valid) && $stable(cmp_wb_data);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("state moved while clock enable low");

  property p_cmp_dest;
    @(posedge sys_clk) disable iff (srst)
      (s_go(gblc_pkg::OP_CMP_LEQ) or s_go(gblc_pkg::OP_CMP_LEQI))
        |=> cmp_wb_valid && (cmp_wb_dest == $past(issue_dest));
  endproperty
  a_cmp_dest: assert property (p_cmp_dest)
    else $error("compare write-back to wrong destination");

  // negative displacement: adding 128 back must give source plus raw field
  property p_ld_disp_neg;
    @(posedge sys_clk) disable iff (srst)
      s_go(gblc_pkg::OP_LD_DISP) ##0 issue_modifier[6] |=>
        (mem_addr + 32'h80) == ($past(first_source_register) + {25'h0, $past(issue_modifier)});
  endproperty
  a_ld_disp_neg: assert property (p_ld_disp_neg)
    else $error("negative displacement not sign-extended");

  // no result stage entered: destination and data registers keep their values
  property p_ld_hold;
    @(posedge sys_clk) disable iff (srst)
      (clk_en && !ld_q.s2_vld) |=> $stable(ld_wb_dest) && $stable(ld_wb_data);
  endproperty
  a_ld_hold: assert property (p_ld_hold)
    else $error("load destination or data moved without a load");

  // reset acts whatever clk_en says; no disable clause here
  property p_reset_clear;
    @(posedge sys_clk)
      srst |=> !mem_req && !ld_wb_valid && !cmp_wb_valid && (mem_addr == '0)
        && (ld_wb_data == '0) && (cmp_wb_data == '0);
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("outputs not cleared by reset");

endmodule : gblc_slice
`default_nettype wire
